// [src/crg_clock_reset_ready.sv]
// Purpose: processor and peripheral clock divider, reset and ready sync
// Assumes: mclk/2 stands in for the crystal; all pins asynchronous
// Notes: generated clocks are data outputs sampled on mclk edges
`timescale 1ns/1ps
`default_nettype none
module crg_clock_reset_ready (
  input wire logic mclk,
  input wire logic srst,
  input wire logic source_select,
  input wire logic ext_freq_in,
  input wire logic clock_sync_in,
  input wire logic reset_in_n,
  input wire logic bus_ready_a_in,
  input wire logic bus_ready_b_in,
  input wire logic ready_enable_a_n,
  input wire logic ready_enable_b_n,
  input wire logic ready_sync_select,
  output logic oscillator_out,
  output logic proc_clock_out,
  output logic periph_clock_out,
  output logic reset_out,
  output logic ready_out,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [crg_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [crg_pkg::PIN_COUNT-1:0] pins_s;
  wire logic [crg_pkg::PIN_COUNT-1:0] pins_raw = {
    ready_sync_select, ready_enable_b_n, ready_enable_a_n, bus_ready_b_in,
    bus_ready_a_in, reset_in_n, clock_sync_in, ext_freq_in};

  // enables idle high, reset input idle high, ready select idle high
  crg_pin_sync #(
    .WIDTH(crg_pkg::PIN_COUNT),
    .INIT(crg_pkg::PIN_IDLE)
  ) u_pins (
    .mclk(mclk),
    .srst(srst),
    .pin(pins_raw),
    .q(pins_s)
  );

  // the source strap is a pin as well; a switch in flight must not tear
  // the choice of divider tick
  logic src_sel_s;

  crg_pin_sync #(
    .WIDTH(1),
    .INIT(1'b0)
  ) u_src_sel (
    .mclk(mclk),
    .srst(srst),
    .pin(source_select),
    .q(src_sel_s)
  );

  logic src_ext;
  wire logic ext_s = pins_s[0];
  wire logic sync_s = pins_s[1];
  wire logic reset_in_n_n_s = pins_s[2];
  wire logic rdy_a_s = pins_s[3];
  wire logic rdy_b_s = pins_s[4];
  wire logic en_a_n_s = pins_s[5];
  wire logic en_b_n_s = pins_s[6];
  wire logic rdy_one_stage = pins_s[7];

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  logic [crg_pkg::CTRL_W-1:0] ctrl;
  wire logic div_clear = sync_s | ctrl[crg_pkg::CTRL_HOLD_BIT];

  // ----------------------------------------------------------------
  // frequency source and oscillator
  // ----------------------------------------------------------------
  logic ext_d;
  wire logic ext_rise = ext_s & ~ext_d;
  // crystal rate is mclk/2: one source edge per oscillator rise
  wire logic osc_rise = ~oscillator_out;
  wire logic src_tick = src_ext ? ext_rise : osc_rise;

  always_ff @(posedge mclk) begin
    if (srst) begin
      src_ext <= 1'b0;
      ext_d <= 1'b0;
      oscillator_out <= 1'b0;
    end else begin
      src_ext <= src_sel_s;
      ext_d <= ext_s;
      oscillator_out <= src_ext | ~oscillator_out;
    end
  end

  // ----------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------
  logic [crg_pkg::DIV_W-1:0] div_cnt;
  wire logic proc_rise = src_tick & ~div_cnt[0] & ~div_clear;
  wire logic proc_fall = src_tick & div_cnt[0] & ~div_clear;
  wire logic [crg_pkg::DIV_W-1:0] next_div_cnt =
    div_clear ? crg_pkg::DIV_RESET :
    src_tick ? div_cnt + 2'h1 : div_cnt;

  // bit 1 carries only when bit 0 falls, so both stay in phase
  always_ff @(posedge mclk) begin
    if (srst) begin
      div_cnt <= crg_pkg::DIV_RESET;
      proc_clock_out <= 1'b0;
      periph_clock_out <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      proc_clock_out <= next_div_cnt[0];
      periph_clock_out <= next_div_cnt[1];
    end
  end

  // the two clock outputs are bits 0 and 1 of the divider, nothing more
  generate
    if (crg_pkg::DIV_W != 2 || crg_pkg::PIN_COUNT != 8) begin : g_bad_sizes
      $error("divider must be two bits and the pin group eight wide");
    end
  endgenerate

  // ----------------------------------------------------------------
  // reset output
  // ----------------------------------------------------------------
  wire logic next_reset = ~reset_in_n_n_s | ctrl[crg_pkg::CTRL_FORCE_RST_BIT];

  always_ff @(posedge mclk) begin
    if (srst) begin
      reset_out <= 1'b1;
    end else if (proc_fall) begin
      reset_out <= next_reset;
    end
  end

  // ----------------------------------------------------------------
  // ready synchronisation
  // ----------------------------------------------------------------
  logic ready_stage1;
  wire logic ready_qual = (rdy_a_s & ~en_a_n_s) | (rdy_b_s & ~en_b_n_s);
  wire logic ready_src = rdy_one_stage ? ready_qual : ready_stage1;

  // first stage on the rising edge, output on the falling edge; the
  // output moving only on a fall keeps the processor's hold window
  always_ff @(posedge mclk) begin
    if (srst) begin
      ready_stage1 <= 1'b0;
      ready_out <= 1'b0;
    end else begin
      if (proc_rise) begin
        ready_stage1 <= ready_qual;
      end
      if (proc_fall) begin
        ready_out <= ready_src;
      end
    end
  end

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------
  wire logic wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire logic hit_ctrl = wb_adr_i == crg_pkg::CTRL_OFS;
  wire logic hit_status = wb_adr_i == crg_pkg::STATUS_OFS;
  wire logic [crg_pkg::ST_W-1:0] status = {
    ready_qual, src_ext, ready_out, reset_out, periph_clock_out, proc_clock_out};
  wire logic [31:0] rd_data =
    hit_ctrl ? {{(32-crg_pkg::CTRL_W){1'b0}}, ctrl} :
    hit_status ? {{(32-crg_pkg::ST_W){1'b0}}, status} : 32'h0000_0000;

  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrl <= crg_pkg::CTRL_RESET;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req) begin
        wb_dat_o <= wb_we_i ? 32'h0000_0000 : rd_data;
      end
      if (wb_req && wb_we_i && hit_ctrl && wb_sel_i[0]) begin
        ctrl <= wb_dat_i[crg_pkg::CTRL_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  a_proc_toggles_tick: assert property (
    src_tick && !div_clear |=> proc_clock_out != $past(proc_clock_out))
    else $error("processor clock missed a source edge");

  a_proc_steady_idle: assert property (
    !src_tick && !div_clear |=> $stable(proc_clock_out))
    else $error("processor clock moved without a source edge");

  a_periph_on_fall: assert property (
    $changed(periph_clock_out) && !$past(div_clear) |-> $fell(proc_clock_out))
    else $error("peripheral clock changed off a processor fall");

  a_periph_half_rate: assert property (
    $fell(proc_clock_out) && !$past(div_clear) |->
      periph_clock_out != $past(periph_clock_out))
    else $error("peripheral clock did not toggle on processor fall");

  a_crystal_drives: assert property (
    !src_ext && !oscillator_out && !div_clear |=> $changed(proc_clock_out))
    else $error("crystal edge did not advance the divider");

  a_osc_stopped: assert property (
    src_ext |=> oscillator_out)
    else $error("oscillator output not high in external mode");

  a_osc_running: assert property (
    !src_ext ##1 !src_ext |-> oscillator_out != $past(oscillator_out))
    else $error("oscillator output not toggling in crystal mode");

  a_sync_clears: assert property (
    div_clear |=> !proc_clock_out && !periph_clock_out)
    else $error("sync did not clear the divider");

  a_reset_on_fall: assert property (
    $changed(reset_out) |-> $fell(proc_clock_out))
    else $error("reset output changed off a processor fall");

  a_reset_level: assert property (
    proc_fall && !reset_in_n_n_s |=> reset_out)
    else $error("reset output low while reset input low");

  a_ready_disabled: assert property (
    en_a_n_s && en_b_n_s |-> !ready_qual)
    else $error("disabled ready input reached the ready path");

  a_ready_two_stage: assert property (
    proc_fall && !rdy_one_stage |=> ready_out == $past(ready_stage1))
    else $error("two-stage ready did not take the first stage");

  a_ready_one_stage: assert property (
    proc_fall && rdy_one_stage |=> ready_out == $past(ready_qual))
    else $error("one-stage ready did not take the input");

  a_ready_drop_fall: assert property (
    $fell(ready_out) |-> $past(proc_fall) && !$past(ready_src))
    else $error("ready dropped off a processor fall");

  a_ready_stage_rise: assert property (
    $changed(ready_stage1) |-> $past(proc_rise))
    else $error("first ready stage moved off a processor rise");

  a_ready_rise_fall: assert property (
    $rose(ready_out) |-> $fell(proc_clock_out) && $past(ready_src))
    else $error("ready rose off a processor fall");

  a_ready_steady: assert property (
    !proc_fall |=> $stable(ready_out))
    else $error("ready moved between processor falls");

  a_reset_steady: assert property (
    !proc_fall |=> $stable(reset_out))
    else $error("reset output moved between processor falls");

  a_force_reset: assert property (
    proc_fall && ctrl[crg_pkg::CTRL_FORCE_RST_BIT] |=> reset_out)
    else $error("forced reset did not reach the reset output");

  c_proc_rise: cover property ($rose(proc_clock_out));
  c_ready_rise: cover property ($rose(ready_out));
  c_reset_release: cover property ($fell(reset_out));
  c_ext_mode: cover property (src_ext && $rose(proc_clock_out));
  c_two_stage: cover property (!rdy_one_stage && $rose(ready_out));
endmodule
`default_nettype wire

// [src/crg_pin_sync.sv]
// Purpose: three-stage synchroniser for a group of asynchronous pins
// Assumes: one clock, synchronous active-high reset
// Notes: output moves only when the second and third stages agree
`timescale 1ns/1ps
`default_nettype none
module crg_pin_sync #(
  parameter int WIDTH = crg_pkg::PIN_COUNT,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  wire logic [WIDTH-1:0] agree = ~(s2 ^ s3);

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("crg_pin_sync needs at least one pin");
    end
  endgenerate

  // s1 feeds s2 only; metastability never reaches other logic
  always_ff @(posedge mclk) begin
    if (srst) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
      q <= INIT;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      q <= (agree & s3) | (~agree & q);
    end
  end
endmodule
`default_nettype wire

// [src/crg_pkg.sv]
// Purpose: shared constants of the clock, reset and ready generator
// Assumes: classic Wishbone register port, 32-bit data, byte addresses
// Notes: offsets are byte addresses of aligned words
package crg_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADR_W = 4;
  localparam logic [ADR_W-1:0] CTRL_OFS = 4'h0;
  localparam logic [ADR_W-1:0] STATUS_OFS = 4'h4;

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  localparam int CTRL_HOLD_BIT = 0;
  localparam int CTRL_FORCE_RST_BIT = 1;
  localparam int CTRL_W = 2;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h0;

  // ----------------------------------------------------------------
  // status fields
  // ----------------------------------------------------------------
  localparam int ST_PROC_BIT = 0;
  localparam int ST_PERIPH_BIT = 1;
  localparam int ST_RESET_BIT = 2;
  localparam int ST_READY_BIT = 3;
  localparam int ST_EXT_BIT = 4;
  localparam int ST_QUAL_BIT = 5;
  localparam int ST_W = 6;

  // ----------------------------------------------------------------
  // divider and pin synchroniser
  // ----------------------------------------------------------------
  localparam int DIV_W = 2;
  localparam logic [DIV_W-1:0] DIV_RESET = 2'h0;
  localparam int PIN_STAGES = 3;
  localparam int PIN_COUNT = 8;
  // pins at rest: both enables, reset input and ready select high
  localparam logic [PIN_COUNT-1:0] PIN_IDLE = 8'hE4;
endpackage

// [verif/crg_clock_reset_ready_bench.sv]
// Purpose: self-checking bench for the clock, reset and ready generator
// Assumes: crystal modelled as mclk/2, partner answers on proc clock
// Notes: clock checks count edges over whole periods
`timescale 1ns/1ps
`default_nettype none
module crg_clock_reset_ready_bench;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic source_select = 1'b0;
  logic ext_freq_in = 1'b0;
  logic clock_sync_in = 1'b0;
  logic reset_in_n = 1'b1;
  logic bus_ready_b_in = 1'b0;
  logic ready_enable_a_n = 1'b1;
  logic ready_enable_b_n = 1'b1;
  logic ready_sync_select = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [crg_pkg::ADR_W-1:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = '0;
  logic req = 1'b0;
  logic ext_on = 1'b0;
  logic bus_ready_a_in, oscillator_out, proc_clock_out, periph_clock_out;
  logic reset_out, ready_out, wb_ack_o;
  logic [31:0] wb_dat_o, q;
  int errors = 0;
  int samples_checked = 0;
  int pr, ph, qr, qh, ot, qb, n, l1, l2;

  crg_clock_reset_ready dut (.mclk(mclk), .srst(srst), .source_select(source_select),
    .ext_freq_in(ext_freq_in), .clock_sync_in(clock_sync_in), .reset_in_n(reset_in_n),
    .bus_ready_a_in(bus_ready_a_in), .bus_ready_b_in(bus_ready_b_in),
    .ready_enable_a_n(ready_enable_a_n), .ready_enable_b_n(ready_enable_b_n),
    .ready_sync_select(ready_sync_select), .oscillator_out(oscillator_out),
    .proc_clock_out(proc_clock_out), .periph_clock_out(periph_clock_out),
    .reset_out(reset_out), .ready_out(ready_out), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
  crg_periph_model partner (.mclk(mclk), .srst(srst), .proc_clock(proc_clock_out),
    .req(req), .bus_ready(bus_ready_a_in));

  always #5 mclk = ~mclk;
  // external source at a tenth of mclk
  always begin
    repeat (5) @(posedge mclk);
    if (ext_on) ext_freq_in <= !ext_freq_in;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // counts edges and high samples, whole periods only
  task automatic watch(input int cycles);
    logic p0, q0, o0;
    {pr, ph, qr, qh, ot, qb} = '0;
    @(negedge mclk);
    {p0, q0, o0} = {proc_clock_out, periph_clock_out, oscillator_out};
    repeat (cycles) begin
      @(negedge mclk);
      pr += int'(proc_clock_out && !p0);
      ph += int'(proc_clock_out);
      qr += int'(periph_clock_out && !q0);
      qh += int'(periph_clock_out);
      ot += int'(oscillator_out != o0);
      qb += int'(periph_clock_out != q0 && !(p0 && !proc_clock_out));
      {p0, q0, o0} = {proc_clock_out, periph_clock_out, oscillator_out};
    end
  endtask

  task automatic wait_for(ref logic s, input logic v, output int cnt);
    cnt = 0;
    @(negedge mclk);
    while (s !== v && cnt < 60) begin
      @(negedge mclk);
      cnt++;
    end
  endtask

  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] d);
    int cnt;
    cnt = 0;
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    @(posedge mclk);
    // ack and read data are taken at the edge that samples ack high
    while (wb_ack_o !== 1'b1 && cnt < 50) begin
      @(posedge mclk);
      cnt++;
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge mclk);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_crystal();
    watch(80);
    chk(pr, 20);
    chk(ph, 40);
    chk(qr, 10);
    chk(qh, 40);
    chk(ot, 80);
    chk(qb, 0);
  endtask

  task automatic t_sync();
    @(posedge mclk);
    clock_sync_in <= 1'b1;
    repeat (10) @(posedge mclk);
    watch(20);
    chk(pr, 0);
    chk({proc_clock_out, periph_clock_out}, 0);
    @(posedge mclk);
    clock_sync_in <= 1'b0;
    repeat (10) @(posedge mclk);
    watch(40);
    chk(pr, 10);
  endtask

  task automatic t_reset();
    @(posedge mclk);
    reset_in_n <= 1'b0;
    wait_for(reset_out, 1'b1, n);
    chk(n < 60, 1);
    chk(proc_clock_out, 0);
    @(posedge mclk);
    reset_in_n <= 1'b1;
    wait_for(reset_out, 1'b0, n);
    chk(n < 60, 1);
    chk(proc_clock_out, 0);
  endtask

  // latency taken from the answer edge so the clock phase is fixed
  task automatic t_ready(input logic one_stage, output int lat);
    @(posedge mclk);
    ready_sync_select <= one_stage;
    ready_enable_a_n <= 1'b0;
    req <= 1'b1;
    wait_for(bus_ready_a_in, 1'b1, n);
    wait_for(ready_out, 1'b1, lat);
    chk(lat < 60, 1);
    @(posedge mclk);
    req <= 1'b0;
    wait_for(ready_out, 1'b0, n);
    chk({bus_ready_a_in, n < 60}, 1);
  endtask

  task automatic t_disabled();
    @(posedge mclk);
    ready_enable_a_n <= 1'b1;
    req <= 1'b1;
    bus_ready_b_in <= 1'b1;
    wait_for(ready_out, 1'b1, n);
    chk(ready_out, 0);
    @(posedge mclk);
    ready_enable_b_n <= 1'b0;
    wait_for(ready_out, 1'b1, n);
    chk(ready_out, 1);
    @(posedge mclk);
    {req, bus_ready_b_in, ready_enable_b_n} <= 3'h1;
  endtask

  task automatic t_regs();
    wb(1'b1, crg_pkg::CTRL_OFS, 32'h00000001);
    watch(20);
    chk(pr, 0);
    wb(1'b1, crg_pkg::CTRL_OFS, 32'h00000002);
    wb(1'b0, crg_pkg::CTRL_OFS, 32'h00000000);
    chk(q, 32'h00000002);
    wait_for(reset_out, 1'b1, n);
    wb(1'b0, crg_pkg::STATUS_OFS, 32'h00000000);
    chk(q[crg_pkg::ST_RESET_BIT], 1);
    wb(1'b0, 4'h8, 32'h00000000);
    chk(q, 32'h00000000);
    wb(1'b1, crg_pkg::CTRL_OFS, 32'h00000000);
    wait_for(reset_out, 1'b0, n);
    chk(reset_out, 0);
  endtask

  task automatic t_extern();
    @(posedge mclk);
    source_select <= 1'b1;
    ext_on <= 1'b1;
    repeat (30) @(posedge mclk);
    watch(200);
    chk(pr, 10);
    chk(ph, 100);
    chk(qr, 5);
    chk(qh, 100);
    chk({oscillator_out, ot[0]}, 2);
    chk(ot, 0);
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    wait_for(reset_out, 1'b0, n);
    chk(reset_out, 0);
    t_crystal();
    t_sync();
    t_reset();
    t_ready(1'b0, l2);
    t_ready(1'b1, l1);
    chk(l2 > l1, 1);
    t_disabled();
    t_regs();
    t_extern();
    conclude();
  end

  initial begin
    repeat (5000) @(posedge mclk);
    errors++;
    conclude();
  end
endmodule
`default_nettype wire

// [verif/crg_periph_model.sv]
// Purpose: bus peripheral that answers on the processor clock
// Assumes: the bench raises req for as long as a transfer lasts
// Notes: ready moves only just after a processor clock rise
`timescale 1ns/1ps
`default_nettype none
module crg_periph_model (
  input wire logic mclk,
  input wire logic srst,
  input wire logic proc_clock,
  input wire logic req,
  output logic bus_ready
);
  logic proc_q;
  // ----------------------------------------------------------------
  // answer aligned to the processor clock
  // ----------------------------------------------------------------
  // a synchronous peripheral; answering after the rise leaves half a
  // period of setup before the fall that one-stage mode samples on
  always_ff @(posedge mclk) begin
    proc_q <= proc_clock;
    if (srst) begin
      bus_ready <= 1'b0;
    end else if (!proc_q && proc_clock) begin
      bus_ready <= req;
    end
  end
endmodule
`default_nettype wire
